// ==== src/watchdog_halt_reset_control.sv ====
`timescale 1ns/10ps
`include "wdt_consts.svh"
module watchdog_halt_reset_control
    import wdt_pkg::*;
#(
    parameter int PORT_WIDTH = 8,
    parameter int IRQ_WIDTH = 3,
    parameter int STARTUP_COUNT = `STARTUP_CLOCKS,
    parameter logic [7:0] WAKE_MASK = 8'hFF
) (
    input wire logic clk_in, // system clock, 250 mhz
    input wire logic reset_n_in, // power-up reset, active low
    input wire logic rc_osc_in, // dedicated watchdog oscillator level
    input wire logic ext_reset_n_in, // external reset pin, active low
    input wire logic [PORT_WIDTH-1:0] port_a_in, // port a pins
    input wire logic clear_instr_in, // watchdog clear instruction pulse
    input wire logic halt_instr_in, // halt instruction pulse
    input wire logic [IRQ_WIDTH-1:0] irq_flag_in, // interrupt request flags
    input wire logic [IRQ_WIDTH-1:0] irq_enable_in, // per-source enables
    input wire logic global_irq_en_in, // master interrupt enable
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    // core control
    output logic core_hold_out, // core stalled (halt, startup or dummy cycle)
    output logic sys_osc_en_out, // system oscillator enable
    output logic chip_reset_out, // one-cycle full chip reset
    output logic warm_reset_out, // one-cycle pc and sp clear
    output logic irq_vector_out, // one-cycle: take interrupt vector
    output logic resume_next_out, // one-cycle: continue next instruction
    output logic timeout_flag_out, // status timeout flag
    output logic powerdown_flag_out // status powerdown flag
);
    localparam int CNT_W = `BASE_DIV_BITS + 7;
    localparam logic [10:0] STARTUP_LAST = 11'(STARTUP_COUNT - 1);

    typedef struct packed {
        logic [7:0] prescale;
        logic [7:0] control;
        logic timeout_flag;
        logic powerdown_flag;
        power_state_type pstate;
        wake_cause_type cause;
        logic [10:0] startup_cnt;
        logic [1:0] instr_div;
        logic rc_prev;
        logic [CNT_W-1:0] wdt_cnt;
        logic [IRQ_WIDTH-1:0] irq_at_halt;
        logic [PORT_WIDTH-1:0] port_prev;
        logic ext_prev;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic hold;
        logic osc_en;
        logic chip_rst;
        logic warm_rst;
        logic irq_vec;
        logic resume;
    } ctrl_state_type;

    ctrl_state_type state;
    ctrl_state_type next_state;
    logic [PORT_WIDTH-1:0] port_sync;
    logic ext_n_sync;
    logic rc_sync;

    // pins cross into the clock domain before any use
    sync_2ff #(.WIDTH(PORT_WIDTH + 2)) u_sync (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .async_in({port_a_in, ext_reset_n_in, rc_osc_in}),
        .init_in({{PORT_WIDTH{1'b1}}, 1'b1, 1'b0}),
        .sync_out({port_sync, ext_n_sync, rc_sync})
    );

    logic wdt_en;
    logic wdt_tick;
    logic [CNT_W-1:0] wdt_limit;
    logic wdt_over;
    logic ext_fall;
    logic port_wake;
    logic irq_wake;
    logic irq_take;
    logic do_clear;
    logic do_halt;
    logic aw_go;
    logic w_go;
    logic wr_fire;
    logic [7:0] strobed;

    // event decode shared by the next-state logic
    always_comb begin
        wdt_en = state.control[`CTRL_WDT_EN_BIT];
        // rc edge, or every fourth system clock outside halt, drives the count
        if (state.control[`CTRL_WDT_SRC_BIT]) begin
            wdt_tick = rc_sync && !state.rc_prev;
        end else begin
            wdt_tick = (state.instr_div == 2'h3) &&
                (state.pstate != ST_HALT);
        end
        // 256 base steps times 2^n prescale steps
        wdt_limit = CNT_W'((32'd1 << (`BASE_DIV_BITS +
            32'(state.prescale[2:0]))) - 1);
        wdt_over = wdt_en && wdt_tick && (state.wdt_cnt >= wdt_limit);
        ext_fall = !ext_n_sync && state.ext_prev;
        port_wake = |(state.port_prev & ~port_sync &
            WAKE_MASK[PORT_WIDTH-1:0]);
        // flags already pending at halt entry cannot wake
        irq_wake = |(irq_flag_in & ~state.irq_at_halt);
        irq_take = global_irq_en_in && !core_stack_full() &&
            |(irq_flag_in & irq_enable_in & ~state.irq_at_halt);
        do_clear = clear_instr_in && wdt_en && state.pstate == ST_RUN;
        do_halt = halt_instr_in && state.pstate == ST_RUN;
        aw_go = s_axi_awvalid && !state.aw_held && !state.bvalid;
        w_go = s_axi_wvalid && !state.w_held && !state.bvalid;
        wr_fire = (state.aw_held || aw_go) && (state.w_held || w_go);
        strobed = state.w_held ? state.w_data[7:0] : s_axi_wdata[7:0];
    end

    function automatic logic core_stack_full();
        return state.control[`CTRL_STACK_FULL_BIT];
    endfunction : core_stack_full

    // next-state logic for watchdog, power states, flags and bus
    always_comb begin
        next_state = state;
        next_state.chip_rst = 1'b0;
        next_state.warm_rst = 1'b0;
        next_state.irq_vec = 1'b0;
        next_state.resume = 1'b0;
        next_state.instr_div = state.instr_div + 2'h1;
        next_state.rc_prev = rc_sync;
        next_state.port_prev = port_sync;
        next_state.ext_prev = ext_n_sync;
        if (wdt_en && wdt_tick) begin
            next_state.wdt_cnt = state.wdt_cnt + CNT_W'(1);
        end

        case (state.pstate)
            ST_RUN: begin
                if (do_halt) begin
                    next_state.pstate = ST_HALT;
                    next_state.osc_en = 1'b0;
                    next_state.hold = 1'b1;
                    next_state.powerdown_flag = 1'b1;
                    next_state.timeout_flag = 1'b0;
                    next_state.wdt_cnt = '0;
                    next_state.irq_at_halt = irq_flag_in;
                end else if (wdt_over) begin
                    // run-mode overflow; powerdown left as is
                    next_state.chip_rst = 1'b1;
                    next_state.timeout_flag = 1'b1;
                    next_state.wdt_cnt = '0;
                    next_state.prescale = `PRESCALE_RESET;
                end else if (do_clear) begin
                    next_state.wdt_cnt = '0;
                    next_state.powerdown_flag = 1'b0;
                    next_state.timeout_flag = 1'b0;
                end
            end
            ST_HALT: begin
                // pin reset handled below; others start the delay
                if (wdt_over) begin
                    next_state.cause = WAKE_WDT;
                    next_state.timeout_flag = 1'b1;
                    next_state.wdt_cnt = '0;
                end else if (port_wake) begin
                    next_state.cause = WAKE_PORT;
                end else if (irq_wake) begin
                    next_state.cause = WAKE_IRQ;
                end
                if (wdt_over || port_wake || irq_wake) begin
                    next_state.pstate = ST_STARTUP;
                    next_state.osc_en = 1'b1;
                    next_state.startup_cnt = '0;
                end
            end
            ST_STARTUP: begin
                next_state.startup_cnt = state.startup_cnt + 11'h1;
                if (state.startup_cnt == STARTUP_LAST) begin
                    next_state.startup_cnt = '0;
                    if (state.cause == WAKE_IRQ && irq_take) begin
                        next_state.pstate = ST_DUMMY;
                    end else begin
                        next_state.pstate = ST_RUN;
                        next_state.hold = 1'b0;
                        next_state.cause = WAKE_NONE;
                        next_state.warm_rst = state.cause == WAKE_WDT;
                        next_state.resume = state.cause != WAKE_WDT;
                    end
                end
            end
            ST_DUMMY: begin
                // extra cycle before the service routine
                next_state.pstate = ST_RUN;
                next_state.hold = 1'b0;
                next_state.cause = WAKE_NONE;
                next_state.irq_vec = 1'b1;
            end
            default: begin
                next_state.pstate = ST_RUN;
                next_state.hold = 1'b0;
            end
        endcase

        // pin reset: full init, no startup delay
        if (ext_fall || (!ext_n_sync && state.pstate != ST_RUN)) begin
            if (state.pstate != ST_RUN) begin
                next_state.timeout_flag = 1'b0;
                next_state.powerdown_flag = 1'b1;
            end
            next_state.pstate = ST_RUN;
            next_state.hold = 1'b0;
            next_state.osc_en = 1'b1;
            next_state.cause = WAKE_NONE;
            next_state.chip_rst = 1'b1;
            next_state.prescale = `PRESCALE_RESET;
        end
        if (!ext_n_sync) begin
            next_state.wdt_cnt = '0;
        end

        // axi4-lite write: address and data accepted in either order
        if (aw_go) begin
            next_state.aw_held = 1'b1;
            next_state.aw_addr = s_axi_awaddr;
        end
        if (w_go) begin
            next_state.w_held = 1'b1;
            next_state.w_data = s_axi_wdata;
            next_state.w_strb = s_axi_wstrb;
        end
        if (wr_fire) begin
            next_state.aw_held = 1'b0;
            next_state.w_held = 1'b0;
            next_state.bvalid = 1'b1;
            next_state.bresp = 2'h0;
            if (w_go ? s_axi_wstrb[0] : state.w_strb[0]) begin
                case (aw_go ? s_axi_awaddr : state.aw_addr)
                    `ADDR_PRESCALE: begin
                        if (wdt_en) begin
                            next_state.prescale = strobed;
                        end
                    end
                    `ADDR_STATUS: ; // flags are hardware-owned
                    `ADDR_CONTROL: next_state.control = strobed;
                    default: next_state.bresp = 2'h2;
                endcase
            end else if ((aw_go ? s_axi_awaddr : state.aw_addr) !=
                    `ADDR_PRESCALE &&
                    (aw_go ? s_axi_awaddr : state.aw_addr) != `ADDR_STATUS &&
                    (aw_go ? s_axi_awaddr : state.aw_addr) !=
                    `ADDR_CONTROL) begin
                next_state.bresp = 2'h2;
            end
        end
        if (state.bvalid && s_axi_bready) begin
            next_state.bvalid = 1'b0;
        end

        // axi4-lite read: one cycle after address acceptance
        if (s_axi_arvalid && !state.rvalid) begin
            next_state.rvalid = 1'b1;
            next_state.rresp = 2'h0;
            next_state.rdata = '0;
            case (s_axi_araddr)
                `ADDR_PRESCALE: next_state.rdata[7:0] = state.prescale;
                `ADDR_STATUS: begin
                    next_state.rdata[`STATUS_PDF_BIT] = state.powerdown_flag;
                    next_state.rdata[`STATUS_TO_BIT] = state.timeout_flag;
                end
                `ADDR_CONTROL: next_state.rdata[7:0] = state.control;
                default: next_state.rresp = 2'h2;
            endcase
        end else if (state.rvalid && s_axi_rready) begin
            next_state.rvalid = 1'b0;
        end
    end

    // power-up reset clears both flags and starts the startup delay
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            state <= '0;
            state.prescale <= `PRESCALE_RESET;
            state.control <= `CONTROL_RESET;
            state.pstate <= ST_STARTUP;
            state.cause <= WAKE_NONE;
            state.hold <= 1'b1;
            state.osc_en <= 1'b1;
            state.port_prev <= '1;
            state.ext_prev <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    assign s_axi_awready = !state.aw_held && !state.bvalid;
    assign s_axi_wready = !state.w_held && !state.bvalid;
    assign s_axi_bvalid = state.bvalid;
    assign s_axi_bresp = state.bresp;
    assign s_axi_arready = !state.rvalid;
    assign s_axi_rvalid = state.rvalid;
    assign s_axi_rdata = state.rdata;
    assign s_axi_rresp = state.rresp;
    assign core_hold_out = state.hold;
    assign sys_osc_en_out = state.osc_en;
    assign chip_reset_out = state.chip_rst;
    assign warm_reset_out = state.warm_rst;
    assign irq_vector_out = state.irq_vec;
    assign resume_next_out = state.resume;
    assign timeout_flag_out = state.timeout_flag;
    assign powerdown_flag_out = state.powerdown_flag;
endmodule : watchdog_halt_reset_control

// ==== inc/wdt_consts.svh ====
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH
// register indices; the bus byte address is four times the index
`define IDX_PRESCALE 8'h09
`define IDX_STATUS 8'h0A
`define IDX_CONTROL 8'h10
`define ADDR_PRESCALE (`IDX_PRESCALE << 2)
`define ADDR_STATUS (`IDX_STATUS << 2)
`define ADDR_CONTROL (`IDX_CONTROL << 2)
// field positions
`define STATUS_PDF_BIT 4
`define STATUS_TO_BIT 5
`define CTRL_WDT_EN_BIT 0
`define CTRL_WDT_SRC_BIT 1
`define CTRL_STACK_FULL_BIT 2
// reset values
`define PRESCALE_RESET 8'h07
`define CONTROL_RESET 8'h01
// timing
`define INSTR_DIV 4
`define BASE_DIV_BITS 8
`define STARTUP_CLOCKS 1024
`endif

// ==== inc/wdt_pkg.sv ====
package wdt_pkg;
    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_HALT = 4'h2,
        ST_STARTUP = 4'h4,
        ST_DUMMY = 4'h8
    } power_state_type;
    typedef enum logic [1:0] {
        WAKE_NONE = 2'h0,
        WAKE_PORT = 2'h1,
        WAKE_IRQ = 2'h2,
        WAKE_WDT = 2'h3
    } wake_cause_type;
endpackage : wdt_pkg

// ==== src/sync_2ff.sv ====
`timescale 1ns/10ps
// two-flop synchroniser; first stage is read only by the second
module sync_2ff #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in, // clock
    input wire logic reset_n_in, // sync reset, active low
    input wire logic [WIDTH-1:0] async_in, // asynchronous level
    input wire logic [WIDTH-1:0] init_in, // value held during reset
    output logic [WIDTH-1:0] sync_out // synchronised level
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_type;
    sync_state_type state;
    sync_state_type next_state;

    // shift one stage per clock
    always_comb begin
        next_state.meta = async_in;
        next_state.stable = state.meta;
    end

    // init comes from constants at the instance, so reset stays constant
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            state <= {init_in, init_in};
        end else begin
            state <= next_state;
        end
    end

    assign sync_out = state.stable;
endmodule : sync_2ff

// ==== tb/watchdog_halt_reset_control_props.sv ====
`timescale 1ns/10ps
// watches the block from its ports only
module watchdog_halt_reset_control_props #(
    parameter int STARTUP_COUNT = 16
) (
    input wire logic clk_in, // clock
    input wire logic reset_n_in, // power-up reset, active low
    input wire logic halt_instr_in, // halt pulse
    input wire logic s_axi_awvalid, // write address valid
    input wire logic s_axi_awready, // write address ready
    input wire logic s_axi_wvalid, // write data valid
    input wire logic s_axi_wready, // write data ready
    input wire logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [1:0] s_axi_bresp, // write response
    input wire logic s_axi_arvalid, // read address valid
    input wire logic s_axi_arready, // read address ready
    input wire logic s_axi_rvalid, // read data valid
    input wire logic core_hold_out, // core stalled
    input wire logic sys_osc_en_out, // oscillator enable
    input wire logic chip_reset_out, // chip reset pulse
    input wire logic warm_reset_out, // warm reset pulse
    input wire logic irq_vector_out, // vector pulse
    input wire logic resume_next_out, // resume pulse
    input wire logic timeout_flag_out, // timeout flag
    input wire logic powerdown_flag_out // powerdown flag
);
    logic [15:0] hold_cnt;
    // stalled cycles since the oscillator last restarted; kept after
    // release so a late vector pulse still sees the full count
    always_ff @(posedge clk_in) begin
        if (!reset_n_in || !sys_osc_en_out) begin
            hold_cnt <= 16'h0000;
        end else if (core_hold_out) begin
            hold_cnt <= hold_cnt + 16'h0001;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    a_halt_entry:
        assert property (halt_instr_in && !core_hold_out |=> core_hold_out
            && !sys_osc_en_out && powerdown_flag_out && !timeout_flag_out)
        else $error("halt entry state wrong");
    a_startup_len:
        assert property (resume_next_out || warm_reset_out || irq_vector_out
            |-> hold_cnt >= 16'(STARTUP_COUNT - 1)
            && hold_cnt <= 16'(STARTUP_COUNT + 3))
        else $error("startup delay length wrong");
    a_warm_flags:
        assert property (warm_reset_out |-> timeout_flag_out
            && powerdown_flag_out) else $error("warm reset flags wrong");
    a_halt_stall:
        assert property (!sys_osc_en_out |-> core_hold_out
            && powerdown_flag_out) else $error("halt not stalled");
    a_timeout_cause:
        assert property ($rose(timeout_flag_out) && !core_hold_out
            |-> ##[0:1] (chip_reset_out || $past(chip_reset_out)))
        else $error("timeout without chip reset");
    a_resume_only:
        assert property (resume_next_out |-> !irq_vector_out
            && !warm_reset_out && !chip_reset_out)
        else $error("resume with other pulse");
    a_b_answer:
        assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
            && s_axi_wready |=> s_axi_bvalid) else $error("no write resp");
    a_b_stands:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
            && $stable(s_axi_bresp)) else $error("write resp dropped");
    a_r_answer:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read data");
    a_ar_refuse:
        assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    c_halt: cover property (halt_instr_in && !core_hold_out);
    c_warm: cover property (warm_reset_out);
    c_vector: cover property (irq_vector_out);
    c_chip: cover property (chip_reset_out);
endmodule : watchdog_halt_reset_control_props

// ==== tb/core_side_model.sv ====
`timescale 1ns/10ps
// core and watchdog oscillator standing beside the block
module core_side_model #(
    parameter int RC_HALF_NS = 10
) (
    input wire logic clk_in, // system clock
    input wire logic core_hold_in, // core stalled
    input wire logic want_clear_in, // bench asks for a clear
    input wire logic want_halt_in, // bench asks for a halt
    output logic rc_osc_out, // free-running watchdog oscillator
    output logic clear_out, // clear instruction pulse
    output logic halt_out // halt instruction pulse
);
    initial begin
        rc_osc_out = 1'b0;
        clear_out = 1'b0;
        halt_out = 1'b0;
    end
    // the rc oscillator keeps running in halt, unrelated to clk_in
    always #(RC_HALF_NS) rc_osc_out = ~rc_osc_out;
    // a stalled core executes nothing, so requests are dropped then
    always @(posedge clk_in) begin
        clear_out <= want_clear_in && !core_hold_in;
        halt_out <= want_halt_in && !core_hold_in;
    end
endmodule : core_side_model

// ==== tb/watchdog_halt_reset_control_tb.sv ====
`timescale 1ns/10ps
`include "wdt_consts.svh"
module watchdog_halt_reset_control_tb;
    logic clk_in = 1'b0, reset_n = 1'b0, ext_n = 1'b1, gie = 1'b0;
    logic [7:0] port_a = 8'hFF, awaddr = 8'h00, araddr = 8'h00;
    logic [2:0] irq_flag = 3'h0, irq_en = 3'h0;
    logic want_clear = 1'b0, want_halt = 1'b0, rc_osc, clear_i, halt_i;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic hold, osc_en, chip_rst, warm_rst, irq_vec, resume, to_f, pd_f;
    int err_total = 0, checked = 0, base;
    int n_chip = 0, n_warm = 0, n_vec = 0, n_res = 0;
    watchdog_halt_reset_control #(.STARTUP_COUNT(16)) u_dut (
        .clk_in(clk_in), .reset_n_in(reset_n), .rc_osc_in(rc_osc),
        .ext_reset_n_in(ext_n), .port_a_in(port_a),
        .clear_instr_in(clear_i), .halt_instr_in(halt_i),
        .irq_flag_in(irq_flag), .irq_enable_in(irq_en),
        .global_irq_en_in(gie), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .core_hold_out(hold),
        .sys_osc_en_out(osc_en), .chip_reset_out(chip_rst),
        .warm_reset_out(warm_rst), .irq_vector_out(irq_vec),
        .resume_next_out(resume), .timeout_flag_out(to_f),
        .powerdown_flag_out(pd_f));
    core_side_model u_core (.clk_in(clk_in), .core_hold_in(hold),
        .want_clear_in(want_clear), .want_halt_in(want_halt),
        .rc_osc_out(rc_osc), .clear_out(clear_i), .halt_out(halt_i));
    always #2 clk_in = ~clk_in;
    // tally one-cycle pulses so that no wait can miss one
    always @(posedge clk_in) begin
        n_chip <= n_chip + int'(chip_rst === 1'b1);
        n_warm <= n_warm + int'(warm_rst === 1'b1);
        n_vec <= n_vec + int'(irq_vec === 1'b1);
        n_res <= n_res + int'(resume === 1'b1);
    end
    task check(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            err_total++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check
    task flags(input logic [1:0] want);
        check(32'({to_f, pd_f}), 32'(want));
    endtask : flags
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk_in);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(negedge clk_in);
            aw_ok = aw_ok || (awvalid && awready);
            w_ok = w_ok || (wvalid && wready);
            @(posedge clk_in);
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
        end
        do @(negedge clk_in); while (bvalid !== 1'b1);
        check(32'(bresp), 32'h0);
        @(posedge clk_in);
        bready <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] want, input logic [1:0] r);
        @(posedge clk_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge clk_in); while (arready !== 1'b1);
        @(posedge clk_in);
        arvalid <= 1'b0;
        do @(negedge clk_in); while (rvalid !== 1'b1);
        check(rdata, want);
        check(32'(rresp), 32'(r));
        @(posedge clk_in);
        rready <= 1'b0;
    endtask : rd
    task instr(input logic h);
        @(posedge clk_in);
        want_halt <= h;
        want_clear <= !h;
        @(posedge clk_in);
        want_halt <= 1'b0;
        want_clear <= 1'b0;
        repeat (2) @(posedge clk_in);
        #1;
    endtask : instr
    task automatic wait_for(ref int cnt, input int lo, input int hi);
        int start;
        int i;
        start = cnt;
        i = 0;
        while (cnt == start && i < hi) begin
            @(posedge clk_in);
            i++;
        end
        #1;
        check(32'(cnt - start), 32'h1);
        check(32'(i >= lo), 32'h1);
    endtask : wait_for
    task pin_reset;
        base = n_chip;
        @(posedge clk_in);
        ext_n <= 1'b0;
        repeat (4) @(posedge clk_in);
        ext_n <= 1'b1;
        repeat (20) @(posedge clk_in);
        #1;
        check(32'(n_chip - base), 32'h1);
    endtask : pin_reset
    task close_out;
        $display("mismatches %0d of %0d checks", err_total, checked);
        if (err_total == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out
    // a hang costs one mismatch and ends the run the normal way
    initial begin
        #300000;
        err_total++;
        close_out();
    end
    initial begin
        repeat (20) @(posedge clk_in);
        reset_n <= 1'b1;
        wait_for(n_res, 14, 200);
        flags(2'b00);
        rd(`ADDR_PRESCALE, 32'h07, 2'h0);
        rd(`ADDR_CONTROL, 32'h01, 2'h0);
        rd(8'h20, 32'h0, 2'h2);
        wr(`ADDR_PRESCALE, 32'h05);
        rd(`ADDR_PRESCALE, 32'h05, 2'h0);
        wr(`ADDR_STATUS, 32'h30);
        rd(`ADDR_STATUS, 32'h00, 2'h0);
        wr(`ADDR_PRESCALE, 32'h01);
        base = n_chip;
        repeat (4) begin
            repeat (1500) @(posedge clk_in);
            instr(1'b0);
        end
        check(32'(n_chip - base), 32'h0);
        wait_for(n_chip, 2000, 2100);
        flags(2'b10);
        rd(`ADDR_PRESCALE, 32'h07, 2'h0);
        instr(1'b1);
        check(32'({hold, osc_en}), 32'h2);
        flags(2'b01);
        rd(`ADDR_STATUS, 32'h10, 2'h0);
        port_a <= 8'hFE;
        wait_for(n_res, 14, 200);
        port_a <= 8'hFF;
        instr(1'b0);
        flags(2'b00);
        irq_en <= 3'h1;
        gie <= 1'b1;
        instr(1'b1);
        irq_flag <= 3'h1;
        wait_for(n_vec, 15, 200);
        irq_flag <= 3'h0;
        gie <= 1'b0;
        instr(1'b1);
        irq_flag <= 3'h1;
        wait_for(n_res, 14, 200);
        gie <= 1'b1;
        instr(1'b1);
        repeat (200) @(posedge clk_in);
        check(32'(hold), 32'h1);
        port_a <= 8'hFE;
        repeat (100) @(posedge clk_in);
        check(32'(hold), 32'h0);
        port_a <= 8'hFF;
        irq_flag <= 3'h0;
        gie <= 1'b0;
        wr(`ADDR_CONTROL, 32'h03);
        wr(`ADDR_PRESCALE, 32'h00);
        instr(1'b0);
        wait_for(n_chip, 1150, 1700);
        flags(2'b10);
        wr(`ADDR_CONTROL, 32'h03);
        wr(`ADDR_PRESCALE, 32'h00);
        base = n_chip;
        instr(1'b1);
        wait_for(n_warm, 1200, 1800);
        flags(2'b11);
        check(32'(n_chip - base), 32'h0);
        wr(`ADDR_CONTROL, 32'h01);
        pin_reset();
        flags(2'b11);
        check(32'(hold), 32'h0);
        rd(`ADDR_PRESCALE, 32'h07, 2'h0);
        instr(1'b1);
        pin_reset();
        flags(2'b01);
        check(32'(hold), 32'h0);
        wr(`ADDR_CONTROL, 32'h00);
        wr(`ADDR_PRESCALE, 32'h03);
        rd(`ADDR_PRESCALE, 32'h07, 2'h0);
        instr(1'b0);
        flags(2'b01);
        close_out();
    end
endmodule : watchdog_halt_reset_control_tb
bind watchdog_halt_reset_control watchdog_halt_reset_control_props #(
    .STARTUP_COUNT(STARTUP_COUNT)) u_props (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .halt_instr_in(halt_instr_in),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .core_hold_out(core_hold_out), .sys_osc_en_out(sys_osc_en_out),
    .chip_reset_out(chip_reset_out), .warm_reset_out(warm_reset_out),
    .irq_vector_out(irq_vector_out), .resume_next_out(resume_next_out),
    .timeout_flag_out(timeout_flag_out),
    .powerdown_flag_out(powerdown_flag_out));
